// File: core/qlsc_defines.svh
// Purpose: Constants of the quad low-side serial control block.
// Assumes: 100 MHz system clock.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
`ifndef QLSC_DEFINES_SVH
`define QLSC_DEFINES_SVH
`define QLSC_CHANNELS         4
`define QLSC_CLK_MHZ          100
`define QLSC_DEGLITCH_NS      3500
`define QLSC_DEGLITCH_CYC     ((`QLSC_DEGLITCH_NS * `QLSC_CLK_MHZ + 999) / 1000)
`define QLSC_RETRY_US         1200
`define QLSC_RETRY_CYC        (`QLSC_RETRY_US * `QLSC_CLK_MHZ)
`define QLSC_STARTUP_US       55
`define QLSC_STARTUP_CYC      (`QLSC_STARTUP_US * `QLSC_CLK_MHZ)
`define QLSC_RESET_PULSE_US   20
`define QLSC_RESET_PULSE_CYC  (`QLSC_RESET_PULSE_US * `QLSC_CLK_MHZ)
// No minimum is known for the reset-to-clock delay, so a wide margin is kept.
`define QLSC_RESET_DELAY_US   5
`define QLSC_RESET_DELAY_CYC  (`QLSC_RESET_DELAY_US * `QLSC_CLK_MHZ)
`define QLSC_HOLD_RESET       4'h0
`endif

// File: core/qlsc_pkg.sv
// Purpose: Types of the quad low-side serial control block.
// Assumes: Four channels.
// Notes:   Pin groups travel as packed structs.
`include "qlsc_defines.svh"
package qlsc_pkg;
   typedef struct packed {
      logic shiftClock;
      logic serialIn;
      logic latch;
   } qlsc_serial_t;
   typedef struct packed {
      logic                        thermalShutdown;
      logic                        undervoltageLockout;
      logic [`QLSC_CHANNELS-1:0]   overcurrentTrip;
   } qlsc_sense_t;
   typedef enum logic [1:0] {CH_RUN, CH_DEGLITCH, CH_RETRY} qlsc_chan_t;
endpackage

// File: core/qlsc_serial_control.sv
// Purpose: Serial shift/latch control and fault handling of a four-channel low-side driver.
// Assumes: All pin inputs are asynchronous to clk and are synchronised by two flip-flops.
// Notes:   The serial clock is sampled; its rising edge is found from the synchronised copy.
// Functional notes
// - Each shift-clock rising edge shifts serial input into the holding register.
// - Oldest holding bit appears on serial output for daisy chaining.
// - Latch rising edge copies holding register to output stage; shifting alone does not.
// - Drivers conduct only while the active-low enable is low.
// - Enable gates only drivers; shift, serial out and latch keep working.
// - Reset pin high clears logic, overcurrent faults and both registers.
// - Internal power-up reset clears logic without host action.
// - Overcurrent persisting for deglitch time disables channel and pulls fault low.
// - After retry time the fault clears, channel re-enables, fault releases.
// - Reset pin or supply loss clears pending overcurrent fault at once.
// - Over-temperature disables all outputs and holds fault low while active.
// - Undervoltage disables everything but a thermal fault flag and holds logic in reset while active.
`timescale 1ns/1ps
`include "qlsc_defines.svh"
module qlsc_serial_control #(
   parameter int DEGLITCH_CYC = `QLSC_DEGLITCH_CYC,
   parameter int RETRY_CYC    = `QLSC_RETRY_CYC
) (
   input  wire logic                      clk,
   input  wire logic                      rstn,
   input  wire qlsc_pkg::qlsc_serial_t    serialPins,
   input  wire logic                      resetPin,
   input  wire logic                      outputEnable_n,
   input  wire qlsc_pkg::qlsc_sense_t     sense,
   output logic                           serialOut,
   output logic [`QLSC_CHANNELS-1:0]      channelOn,
   output logic [`QLSC_CHANNELS-1:0]      outputStage,
   output logic                           faultFlagOut,
   output logic                           faultFlagOe
);
   import qlsc_pkg::*;

   localparam int N = `QLSC_CHANNELS;

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers: first stage is read only by the second.
   // Three serial pins, reset, enable, thermal, undervoltage and one trip bit per channel.
   logic [N+6:0] syncA;
   logic [N+6:0] syncB;
   logic         clkPrev;
   logic         latchPrev;
   logic         powerUpDone;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         syncA <= '0;
         syncB <= '0;
      end else begin
         syncA <= {serialPins, resetPin, outputEnable_n, sense};
         syncB <= syncA;
      end
   end

   logic                  sClk;
   logic                  sIn;
   logic                  sLatch;
   logic                  sReset;
   logic                  sEnable_n;
   logic                  sThermal;
   logic                  sUnder;
   logic [N-1:0]          sTrip;
   assign {sClk, sIn, sLatch, sReset, sEnable_n, sThermal, sUnder, sTrip} = syncB;

   // The chip reset combines rstn, the host reset pin, power-up and undervoltage.
   logic logicReset;
   assign logicReset = !rstn || !powerUpDone || sReset || sUnder;

   // Power-up reset holds the logic cleared until the synchronisers have filled.
   logic [1:0] powerCnt;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         powerCnt    <= 2'h0;
         powerUpDone <= 1'b0;
      end else if (!powerUpDone) begin
         powerCnt    <= powerCnt + 2'h1;
         powerUpDone <= (powerCnt == 2'h3);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Edge detection on the sampled serial clock and latch.
   // In reset the previous levels follow the pins, so an edge that fell inside reset is not acted on later.
   always_ff @(posedge clk) begin
      if (logicReset) begin
         clkPrev   <= sClk;
         latchPrev <= sLatch;
      end else begin
         clkPrev   <= sClk;
         latchPrev <= sLatch;
      end
   end

   logic clkRise;
   logic latchRise;
   assign clkRise   = sClk && !clkPrev;
   assign latchRise = sLatch && !latchPrev;

   ////////////////////////////////////////////////////////////////////////////
   // Holding shift register and output stage; enable plays no part here.
   logic [N-1:0] holding;

   always_ff @(posedge clk) begin
      if (logicReset) begin
         holding <= `QLSC_HOLD_RESET;
      end else if (clkRise) begin
         holding <= {holding[N-2:0], sIn};
      end
   end

   always_ff @(posedge clk) begin
      if (logicReset) begin
         serialOut <= 1'b0;
      end else begin
         serialOut <= holding[N-1];
      end
   end

   always_ff @(posedge clk) begin
      if (logicReset) begin
         outputStage <= `QLSC_HOLD_RESET;
      end else if (latchRise) begin
         outputStage <= holding;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel overcurrent: deglitch, then timed retry with the driver off.
   // One counter per channel is sized for the longer retry interval.
   localparam int CW = $clog2(RETRY_CYC + 1);
   qlsc_chan_t    chState [N];
   logic [CW-1:0] chCount [N];
   logic [N-1:0]  chFault;

   for (genvar i = 0; i < N; i++) begin : g_chan
      always_ff @(posedge clk) begin
         if (logicReset) begin
            chState[i] <= CH_RUN;
            chCount[i] <= '0;
         end else begin
            unique case (chState[i])
               CH_RUN: begin
                  chCount[i] <= CW'(1);
                  if (sTrip[i]) begin
                     chState[i] <= CH_DEGLITCH;
                  end
               end
               CH_DEGLITCH: begin
                  if (!sTrip[i]) begin
                     chState[i] <= CH_RUN;
                  end else if (chCount[i] >= CW'(DEGLITCH_CYC)) begin
                     chState[i] <= CH_RETRY;
                     chCount[i] <= CW'(1);
                  end else begin
                     chCount[i] <= chCount[i] + CW'(1);
                  end
               end
               // A trip seen during retry is ignored; the channel is already off.
               CH_RETRY: begin
                  if (chCount[i] >= CW'(RETRY_CYC)) begin
                     chState[i] <= CH_RUN;
                  end else begin
                     chCount[i] <= chCount[i] + CW'(1);
                  end
               end
            endcase
         end
      end
      assign chFault[i] = (chState[i] == CH_RETRY);

      // Channel checks run once per channel, so whichever channel trips is watched.
      chk_deglitch_drop: assert property (@(posedge clk) disable iff (logicReset)
         (chState[i] == CH_DEGLITCH) && !sTrip[i] |=> chState[i] == CH_RUN)
         else $error("short trip was not dropped");

      chk_deglitch_time: assert property (@(posedge clk) disable iff (logicReset)
         $rose(chFault[i]) |-> $past(chCount[i]) >= CW'(DEGLITCH_CYC))
         else $error("fault before deglitch time");

      chk_retry_hold: assert property (@(posedge clk) disable iff (logicReset)
         (chState[i] == CH_RETRY) && (chCount[i] < CW'(RETRY_CYC)) |=> chFault[i])
         else $error("channel left retry early");

      chk_retry_end: assert property (@(posedge clk) disable iff (logicReset)
         (chState[i] == CH_RETRY) && (chCount[i] >= CW'(RETRY_CYC)) |=> !chFault[i])
         else $error("fault not cleared after retry");

      chk_trip_off: assert property (@(posedge clk) disable iff (logicReset)
         chFault[i] |=> !channelOn[i])
         else $error("faulted channel still driven");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Driver gating and fault flag.
   logic [N-1:0] next_channelOn;
   logic         next_fault;
   assign next_channelOn = (sEnable_n || sThermal) ? '0 : (outputStage & ~chFault);
   assign next_fault     = (|chFault) || sThermal;

   always_ff @(posedge clk) begin
      if (logicReset) begin
         channelOn <= '0;
      end else begin
         channelOn <= next_channelOn;
      end
   end

   // Open drain: the pin is only ever pulled low, never driven high.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         faultFlagOe <= 1'b0;
      end else if (logicReset && !sThermal) begin
         faultFlagOe <= 1'b0;
      end else begin
         faultFlagOe <= next_fault;
      end
   end
   // Tied low on purpose: a flop here would only ever hold the same constant.
   assign faultFlagOut = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   chk_enable_gates: assert property (@(posedge clk) disable iff (!rstn)
      sEnable_n |=> channelOn == '0)
      else $error("channel on while enable high");

   chk_latch_copy: assert property (@(posedge clk) disable iff (logicReset)
      latchRise |=> outputStage == $past(holding))
      else $error("latch did not copy holding");

   chk_shift_only: assert property (@(posedge clk) disable iff (logicReset)
      !latchRise |=> $stable(outputStage))
      else $error("output stage changed without latch");

   chk_shift_in: assert property (@(posedge clk) disable iff (logicReset)
      clkRise |=> holding[0] == $past(sIn))
      else $error("serial input not shifted");

   chk_serial_out: assert property (@(posedge clk) disable iff (logicReset)
      1'b1 |=> serialOut == $past(holding[N-1]))
      else $error("serial out not oldest bit");

   chk_reset_clears: assert property (@(posedge clk) disable iff (!rstn)
      sReset |=> holding == '0 && outputStage == '0 && chFault == '0)
      else $error("reset did not clear logic");

   chk_thermal_off: assert property (@(posedge clk) disable iff (!rstn)
      sThermal |=> channelOn == '0 && faultFlagOe)
      else $error("thermal did not disable outputs");

   chk_under_lock: assert property (@(posedge clk) disable iff (!rstn)
      sUnder |=> channelOn == '0 && outputStage == '0)
      else $error("undervoltage did not lock");

   chk_trip_fault: assert property (@(posedge clk) disable iff (logicReset)
      chFault != '0 |=> faultFlagOe)
      else $error("fault flag not pulled low");

   chk_power_up: assert property (@(posedge clk) disable iff (!rstn)
      !powerUpDone |=> holding == '0)
      else $error("power-up reset not held");

   chk_power_hold: assert property (@(posedge clk) disable iff (!rstn)
      powerUpDone |=> powerUpDone)
      else $error("power-up reset came back");

   chk_fault_or: assert property (@(posedge clk) disable iff (logicReset)
      1'b1 |=> faultFlagOe == ($past(chFault != '0) || $past(sThermal)))
      else $error("fault flag not the OR of its causes");

   chk_pin_clears: assert property (@(posedge clk) disable iff (!rstn)
      sReset && !sThermal |=> !faultFlagOe)
      else $error("reset pin did not release fault flag");

   chk_supply_clears: assert property (@(posedge clk)
      !rstn |=> !faultFlagOe && chFault == '0)
      else $error("supply loss did not clear faults");

   chk_enable_drive: assert property (@(posedge clk) disable iff (logicReset)
      !sEnable_n && !sThermal && chFault == '0 |=> channelOn == $past(outputStage))
      else $error("enabled channel not driven");

   chk_under_clear: assert property (@(posedge clk) disable iff (!rstn)
      sUnder |=> holding == '0 && serialOut == 1'b0 && chFault == '0)
      else $error("undervoltage did not clear logic");

   chk_serial_hold: assert property (@(posedge clk) disable iff (logicReset)
      !clkRise |=> $stable(holding))
      else $error("holding changed without shift edge");

   chk_shift_order: assert property (@(posedge clk) disable iff (logicReset)
      clkRise |=> holding[N-1:1] == $past(holding[N-2:0]))
      else $error("holding did not shift toward serial out");

   chk_latch_enable: assert property (@(posedge clk) disable iff (logicReset)
      sEnable_n && latchRise |=> outputStage == $past(holding))
      else $error("latch blocked by enable");
endmodule

// File: testbench/qlsc_host_model.sv
// Purpose: Host controller that drives the serial pins of the quad low-side control block.
// Assumes: Shift clock of 80 ns (8 clk cycles), idle low between frames.
// Notes:   Data changes together with the falling shift-clock edge.
`timescale 1ns/1ps
module qlsc_host_model (
   input  wire logic                   clk,
   output qlsc_pkg::qlsc_serial_t      pins
);
   import qlsc_pkg::*;
   initial pins = '0;
   ////////////////////////////////////////////////////////////////////////////////
   // The pins have pulldowns, so an idle data line rests low.
   task automatic shift(input logic [3:0] d, input int n);
      @(posedge clk);
      for (int i = n - 1; i >= 0; i--) begin
         pins.serialIn <= d[i];
         repeat (4) @(posedge clk);
         pins.shiftClock <= 1'b1;
         repeat (4) @(posedge clk);
         pins.shiftClock <= 1'b0;
      end
      pins.serialIn <= 1'b0;
   endtask
   // A 200 ns pulse keeps the minimum latch width.
   task automatic latch();
      @(posedge clk);
      pins.latch <= 1'b1;
      repeat (20) @(posedge clk);
      pins.latch <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
endmodule

// File: testbench/tb.sv
// Purpose: Self-checking bench for the quad low-side serial control block.
// Assumes: Shortened deglitch (10) and retry (200) counts.
// Notes:   Expected values are queued; a watcher compares them when a strobe appears.
`timescale 1ns/1ps
`include "qlsc_defines.svh"
module tb;
   import qlsc_pkg::*;
   logic           clk;
   logic           rstn;
   logic           resetPin;
   logic           outputEnable_n;
   logic           obsNow;
   qlsc_serial_t   serialPins;
   qlsc_sense_t    sense;
   logic           serialOut;
   logic           faultFlagOut;
   logic           faultFlagOe;
   logic [3:0]     channelOn;
   logic [3:0]     outputStage;
   logic [3:0]     w;
   logic [9:0]     expQ[$];
   int             bad_count = 0;
   int             n_checks = 0;
   qlsc_serial_control #(.DEGLITCH_CYC(10), .RETRY_CYC(200)) i_qlsc_serial_control (
      .clk(clk), .rstn(rstn), .serialPins(serialPins), .resetPin(resetPin),
      .outputEnable_n(outputEnable_n), .sense(sense), .serialOut(serialOut), .channelOn(channelOn),
      .outputStage(outputStage), .faultFlagOut(faultFlagOut), .faultFlagOe(faultFlagOe));
   qlsc_host_model i_qlsc_host_model (.clk(clk), .pins(serialPins));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic note(input logic [9:0] e);
      expQ.push_back(e);
      obsNow <= 1'b1;
      @(posedge clk);
      obsNow <= 1'b0;
   endtask
   function automatic logic [9:0] pk(input logic f, input logic [3:0] c, input logic [3:0] o, input logic s);
      return {f, c, o, s};
   endfunction
   task automatic final_report();
      if (bad_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      if (obsNow === 1'b1 && expQ.size() > 0) begin
         check({faultFlagOe, channelOn, outputStage, serialOut}, expQ.pop_front());
         check(10'(faultFlagOut), 10'h000);
      end
   end
   // A hang counts as a mismatch and still ends in the report.
   initial begin
      cyc(30000);
      bad_count++;
      final_report();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rstn = 1'b0;
      resetPin = 1'b0;
      outputEnable_n = 1'b1;
      obsNow = 1'b0;
      sense = '0;
      w = 4'($urandom(42)) | 4'h8;
      cyc(3);
      rstn <= 1'b1;
      cyc(`QLSC_STARTUP_CYC);
      note(10'h000);
      i_qlsc_host_model.shift(w, 4);
      cyc(6);
      note(pk(1'b0, 4'h0, 4'h0, w[3]));
      i_qlsc_host_model.latch();
      cyc(6);
      note(pk(1'b0, 4'h0, w, w[3]));
      outputEnable_n <= 1'b0;
      cyc(6);
      note(pk(1'b0, w, w, w[3]));
      sense.overcurrentTrip <= 4'h8;
      cyc(20);
      sense.overcurrentTrip <= 4'h0;
      note(pk(1'b1, w & 4'h7, w, w[3]));
      cyc(100);
      note(pk(1'b1, w & 4'h7, w, w[3]));
      cyc(150);
      note(pk(1'b0, w, w, w[3]));
      sense.overcurrentTrip <= 4'h8;
      cyc(20);
      sense.overcurrentTrip <= 4'h0;
      note(pk(1'b1, w & 4'h7, w, w[3]));
      resetPin <= 1'b1;
      cyc(4);
      note(10'h000);
      cyc(`QLSC_RESET_PULSE_CYC);
      resetPin <= 1'b0;
      cyc(6);
      note(10'h000);
      cyc(`QLSC_RESET_DELAY_CYC);
      i_qlsc_host_model.shift(4'hF, 4);
      i_qlsc_host_model.latch();
      cyc(6);
      sense.thermalShutdown <= 1'b1;
      cyc(6);
      note(pk(1'b1, 4'h0, 4'hF, 1'b1));
      sense.thermalShutdown <= 1'b0;
      cyc(6);
      note(pk(1'b0, 4'hF, 4'hF, 1'b1));
      sense.undervoltageLockout <= 1'b1;
      cyc(8);
      note(10'h000);
      sense.undervoltageLockout <= 1'b0;
      cyc(8);
      i_qlsc_host_model.shift(4'h5, 4);
      i_qlsc_host_model.latch();
      cyc(6);
      note(pk(1'b0, 4'h5, 4'h5, 1'b0));
      sense.overcurrentTrip <= 4'h1;
      cyc(20);
      note(pk(1'b1, 4'h4, 4'h5, 1'b0));
      sense.overcurrentTrip <= 4'h0;
      rstn <= 1'b0;
      cyc(3);
      rstn <= 1'b1;
      cyc(2);
      note(10'h000);
      cyc(`QLSC_STARTUP_CYC);
      i_qlsc_host_model.shift(w, 4);
      i_qlsc_host_model.latch();
      cyc(6);
      note(pk(1'b0, w, w, w[3]));
      final_report();
   end
endmodule
